// >>> src/rxsw_top.sv
// rx status word builder with fifo flush control and wishbone registers
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "rxsw_defs.svh"
module rxsw_top #(
  parameter int LEN_W = 14
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // frame events from mac and filter engine
  input wire logic frm_start_i,
  input wire logic frm_end_i,
  input wire logic phy_err_i,
  input wire rxsw_pkg::rxsw_frame_s frm_i,
  // power state
  input wire logic susp3_i,
  input wire logic store_wake_i,
  input wire logic pass_wake_i,
  // fifo side
  output logic fifo_we_o,
  output rxsw_pkg::rxsw_sel_e fifo_sel_o,
  output logic [31:0] fifo_wdata_o,
  output logic fifo_commit_o,
  output logic fifo_rewind_o,
  output logic fifo_ptr_rst_o,
  // mac control and interrupt
  output logic mac_receive_register_en_o,
  output logic rx_disabled_interrupt_o
);
  if (LEN_W != 14) begin : g_chk
    $error("rxsw_top: length field is 14 bits");
  end

  rxsw_pkg::rxsw_state_e state_r, state_nxt;
  rxsw_pkg::rxsw_frame_s frm_r;
  logic en_r, keep_r, strip_r, flush_r, fdis_r, ien_r;
  logic rxen_r, rxd_r, fdis_pend_r, rxd_pend_r;
  logic [13:0] max_r;
  logic rxe_seen_r;
  logic [31:0] wa_r, wb_r, wc_r;
  logic [31:0] last_a_r;
  logic [15:0] ok_cnt_r, drop_cnt_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic we_r, commit_r, rew_r, prst_r, int_r;
  rxsw_pkg::rxsw_sel_e sel_r;
  logic [31:0] wdata_r;

  // bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire bus_wr = bus_req & wb_we_i;
  wire hit_ctl = wb_adr_i == `RXSW_CTL_OFF;
  wire hit_mac = wb_adr_i == `RXSW_MAC_OFF;
  wire hit_sta = wb_adr_i == `RXSW_STA_OFF;
  wire hit_cnt = wb_adr_i == `RXSW_CNT_OFF;
  wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wset = wb_dat_i & bmask;

  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~bmask) | wset;
  endfunction

  wire [31:0] ctl_rd = {26'h0, ien_r, fdis_r, flush_r, strip_r, keep_r, en_r};
  wire [31:0] mac_rd = {2'h0, max_r, 14'h0, rxd_r, rxen_r};
  wire [31:0] ctl_new = merge(ctl_rd);
  wire [31:0] mac_new = merge(mac_rd);
  wire ctl_wr = bus_wr & hit_ctl;
  wire mac_wr = bus_wr & hit_mac;
  wire [31:0] rd_mux = hit_ctl ? ctl_rd :
                       hit_mac ? mac_rd :
                       hit_sta ? last_a_r :
                       hit_cnt ? {drop_cnt_r, ok_cnt_r} : 32'h0;

  // per-frame flag derivation from the end-of-frame snapshot
  wire rxe_any = rxe_seen_r | phy_err_i;
  wire runt_now = (frm_i.bytes < `RXSW_RUNT_BYTES) | frm_i.short_frm;
  wire wdt_now = frm_i.wd_trunc | (frm_i.bytes > `RXSW_WD_BYTES);
  wire long_now = frm_i.bytes > max_r;
  wire aln_now = frm_i.dribble & ~frm_i.crc_ok & ~frm_i.gig;
  wire fcs_now = ~frm_i.crc_ok | rxe_any;
  wire mc_now = frm_i.da_msb[0] & ~frm_i.bcast;
  wire uc_now = ~frm_i.da_msb[0];
  wire ck_err_now = frm_i.ip_err | (frm_i.l4_err & ~frm_i.ck_ign);
  wire [13:0] len_now = strip_r ? frm_i.bytes - `RXSW_FCS_BYTES : frm_i.bytes;
  wire err_now = fcs_now | aln_now | rxe_any | long_now | runt_now
                 | wdt_now | ck_err_now;
  wire drop_now = runt_now & ~keep_r;

  function automatic logic [31:0] build_a(input logic mc, vl, er, wd, rn, lg,
                                          rx, al, fc, uc, ci,
                                          input logic [13:0] ln);
    logic [31:0] w;
    w = 32'h0;
    w[`RXSW_A_MCAST] = mc;
    w[`RXSW_A_VLAN] = vl;
    w[`RXSW_A_ERR] = er;
    w[`RXSW_A_WDT] = wd;
    w[`RXSW_A_RUNT] = rn;
    w[`RXSW_A_LONG] = lg;
    w[`RXSW_A_RXE] = rx;
    w[`RXSW_A_ALN] = al;
    w[`RXSW_A_FCS] = fc;
    w[`RXSW_A_UCAST] = uc;
    w[`RXSW_A_CKIGN] = ci;
    w[13:0] = ln;
    build_a = w;
  endfunction

  wire [31:0] a_now = build_a(mc_now, frm_i.vlan, err_now, wdt_now, runt_now,
                              long_now, rxe_any, aln_now, fcs_now, uc_now,
                              frm_i.ck_ign, len_now);
  wire [31:0] b_now = {frm_i.raw_l3_checksum_field, frm_i.vlan ? frm_i.vlan_tag_field : 16'h0};
  wire wake_now = frm_i.wake & susp3_i & store_wake_i;
  wire ffail_now = frm_i.ffail & frm_i.wake & susp3_i & store_wake_i
                   & pass_wake_i;
  wire [31:0] c_now = {16'h0, wake_now, ffail_now, 14'h0};

  wire frm_end_ok = state_r == rxsw_pkg::RXSW_RX & frm_end_i;
  wire accept = frm_start_i & en_r & rxen_r;

  // frame sequencer; a pending flush wins over a frame start in idle, and that start is not kept
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      rxsw_pkg::RXSW_IDLE: begin
        if (flush_r)
          state_nxt = rxsw_pkg::RXSW_FLUSH;
        else if (accept)
          state_nxt = rxsw_pkg::RXSW_RX;
      end
      rxsw_pkg::RXSW_RX: begin
        if (frm_end_i)
          state_nxt = drop_now ? rxsw_pkg::RXSW_DROP : rxsw_pkg::RXSW_WC;
      end
      rxsw_pkg::RXSW_WC: state_nxt = rxsw_pkg::RXSW_WA;
      rxsw_pkg::RXSW_WA: state_nxt = rxsw_pkg::RXSW_WB;
      rxsw_pkg::RXSW_WB: state_nxt = rxsw_pkg::RXSW_IDLE;
      rxsw_pkg::RXSW_DROP: state_nxt = rxsw_pkg::RXSW_IDLE;
      rxsw_pkg::RXSW_FLUSH: state_nxt = rxsw_pkg::RXSW_IDLE;
    endcase
  end

  wire st_wc = state_r == rxsw_pkg::RXSW_WC;
  wire st_wa = state_r == rxsw_pkg::RXSW_WA;
  wire st_wb = state_r == rxsw_pkg::RXSW_WB;
  wire st_idle = state_r == rxsw_pkg::RXSW_IDLE;
  wire st_flush = state_r == rxsw_pkg::RXSW_FLUSH;
  // fifo counts as stopped only between frames, so no frame is cut in half
  wire fdis_done = fdis_pend_r & st_idle;
  wire rxd_done = rxd_pend_r & (state_r != rxsw_pkg::RXSW_RX);
  wire fdis_clr = ctl_wr & wset[`RXSW_CTL_FDIS];
  wire rxd_clr = mac_wr & wset[`RXSW_MAC_RXD];
  wire [31:0] word_nxt = st_wc ? wc_r : st_wa ? wa_r : wb_r;
  rxsw_pkg::rxsw_sel_e sel_nxt;
  assign sel_nxt = st_wc ? rxsw_pkg::RXSW_SEL_C :
                   st_wa ? rxsw_pkg::RXSW_SEL_A : rxsw_pkg::RXSW_SEL_B;

  always_ff @(posedge clk_i) begin
    if (rst_i)
      state_r <= rxsw_pkg::RXSW_IDLE;
    else
      state_r <= state_nxt;
  end

  // frame snapshot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxe_seen_r <= 1'b0;
      frm_r <= '0;
      wa_r <= 32'h0;
      wb_r <= 32'h0;
      wc_r <= 32'h0;
    end else if (st_idle) begin
      rxe_seen_r <= 1'b0;
    end else if (state_r == rxsw_pkg::RXSW_RX) begin
      rxe_seen_r <= rxe_any;
      if (frm_end_i) begin
        frm_r <= frm_i;
        wa_r <= a_now;
        wb_r <= b_now;
        wc_r <= c_now;
      end
    end
  end

  // fifo outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      we_r <= 1'b0;
      sel_r <= rxsw_pkg::RXSW_SEL_A;
      wdata_r <= 32'h0;
      commit_r <= 1'b0;
      rew_r <= 1'b0;
      prst_r <= 1'b0;
    end else begin
      we_r <= st_wc | st_wa | st_wb;
      sel_r <= sel_nxt;
      wdata_r <= word_nxt;
      commit_r <= st_wb;
      rew_r <= state_r == rxsw_pkg::RXSW_DROP;
      prst_r <= st_flush;
    end
  end

  // control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_r <= 1'b0;
      keep_r <= 1'b0;
      strip_r <= 1'b0;
      ien_r <= 1'b0;
      flush_r <= 1'b0;
      fdis_r <= 1'b0;
      fdis_pend_r <= 1'b0;
    end else begin
      if (ctl_wr) begin
        en_r <= ctl_new[`RXSW_CTL_EN];
        keep_r <= ctl_new[`RXSW_CTL_KEEP];
        strip_r <= ctl_new[`RXSW_CTL_STRIP];
        ien_r <= ctl_new[`RXSW_CTL_IEN];
      end
      if (ctl_wr & en_r & ~ctl_new[`RXSW_CTL_EN])
        fdis_pend_r <= 1'b1;
      else if (fdis_done | (ctl_wr & ctl_new[`RXSW_CTL_EN]))
        fdis_pend_r <= 1'b0;
      // set wins over a same-cycle write-one-to-clear
      if (fdis_done)
        fdis_r <= 1'b1;
      else if (fdis_clr)
        fdis_r <= 1'b0;
      if (st_flush)
        flush_r <= 1'b0;
      else if (ctl_wr & wset[`RXSW_CTL_FLUSH])
        flush_r <= 1'b1;
    end
  end

  // mac receive register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxen_r <= 1'b0;
      rxd_r <= 1'b0;
      rxd_pend_r <= 1'b0;
      max_r <= `RXSW_MAX_RST;
    end else begin
      if (mac_wr) begin
        rxen_r <= mac_new[`RXSW_MAC_RXEN];
        max_r <= mac_new[`RXSW_MAC_MAX_LSB +: 14];
      end
      if (mac_wr & rxen_r & ~mac_new[`RXSW_MAC_RXEN])
        rxd_pend_r <= 1'b1;
      else if (rxd_done | (mac_wr & mac_new[`RXSW_MAC_RXEN]))
        rxd_pend_r <= 1'b0;
      if (rxd_done)
        rxd_r <= 1'b1;
      else if (rxd_clr)
        rxd_r <= 1'b0;
    end
  end

  // counters, last status, interrupt, bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ok_cnt_r <= 16'h0;
      drop_cnt_r <= 16'h0;
      last_a_r <= 32'h0;
      int_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      if (st_wb) begin
        ok_cnt_r <= ok_cnt_r + 16'h1;
        last_a_r <= wa_r;
      end
      if (state_r == rxsw_pkg::RXSW_DROP)
        drop_cnt_r <= drop_cnt_r + 16'h1;
      int_r <= ien_r & (fdis_r | rxd_r);
      ack_r <= bus_req;
      dat_r <= bus_req ? rd_mux : 32'h0;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign fifo_we_o = we_r;
  assign fifo_sel_o = sel_r;
  assign fifo_wdata_o = wdata_r;
  assign fifo_commit_o = commit_r;
  assign fifo_rewind_o = rew_r;
  assign fifo_ptr_rst_o = prst_r;
  assign mac_receive_register_en_o = rxen_r;
  assign rx_disabled_interrupt_o = int_r;

  // checks
  wire end_keep = frm_end_ok & ~drop_now;
  sequence s_end;
    end_keep;
  endsequence
  sequence s_word_a;
    fifo_we_o && fifo_sel_o == rxsw_pkg::RXSW_SEL_A;
  endsequence
  sequence s_word_b;
    fifo_we_o && fifo_sel_o == rxsw_pkg::RXSW_SEL_B && fifo_commit_o;
  endsequence
  sequence s_word_c;
    fifo_we_o && fifo_sel_o == rxsw_pkg::RXSW_SEL_C;
  endsequence

  a_mcast_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    s_end |-> ##3 s_word_a ##0 fifo_wdata_o[`RXSW_A_MCAST] == $past(mc_now, 3))
    else $error("multicast flag wrong");
  a_vlan_word: assert property (@(posedge clk_i) disable iff (rst_i)
    s_end ##0 frm_i.vlan |-> ##3 fifo_wdata_o[`RXSW_A_VLAN]
      ##1 fifo_wdata_o[15:0] == frm_r.vlan_tag_field)
    else $error("vlan flag or tag wrong");
  a_err_summary: assert property (@(posedge clk_i) disable iff (rst_i)
    s_end |-> ##3 fifo_wdata_o[`RXSW_A_ERR]
      == (|fifo_wdata_o[21:16] | $past(ck_err_now, 3)))
    else $error("summary error flag wrong");
  a_wdt_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    s_end ##0 frm_i.wd_trunc |-> ##3 fifo_wdata_o[`RXSW_A_WDT])
    else $error("watchdog flag missing");
  a_runt_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    frm_end_ok & runt_now & ~keep_r |-> ##2 fifo_rewind_o & ~fifo_we_o
      ##1 ~fifo_we_o & ~fifo_commit_o)
    else $error("runt frame not discarded");
  a_long_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    s_end |-> ##3 fifo_wdata_o[`RXSW_A_LONG] == $past(long_now, 3))
    else $error("too-long flag wrong");
  a_fcs_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    s_end ##0 rxe_any |-> ##3 fifo_wdata_o[`RXSW_A_FCS] & fifo_wdata_o[`RXSW_A_RXE])
    else $error("fcs flag missing on phy error");
  a_len_field: assert property (@(posedge clk_i) disable iff (rst_i)
    s_end |-> ##3 fifo_wdata_o[13:0] == $past(len_now, 3))
    else $error("length field wrong");
  a_flush_done: assert property (@(posedge clk_i) disable iff (rst_i)
    st_idle & flush_r |-> ##2 fifo_ptr_rst_o & ~flush_r)
    else $error("flush did not reset pointers");
  a_int_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ien_r & (fdis_r | rxd_r) |=> rx_disabled_interrupt_o)
    else $error("disabled interrupt dropped early");
  a_int_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    ~(fdis_r | rxd_r) |=> ~rx_disabled_interrupt_o)
    else $error("disabled interrupt held with both status bits clear");
  a_fdis_set: assert property (@(posedge clk_i) disable iff (rst_i)
    fdis_done |=> fdis_r)
    else $error("fifo disabled status not set");
  a_runt_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    s_end |-> ##3 fifo_wdata_o[`RXSW_A_RUNT] == $past(runt_now, 3))
    else $error("runt flag wrong");
  a_aln_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    s_end |-> ##3 fifo_wdata_o[`RXSW_A_ALN] == $past(aln_now, 3))
    else $error("alignment flag wrong");
  a_ucast_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    s_end |-> ##3 fifo_wdata_o[`RXSW_A_UCAST] == $past(uc_now, 3))
    else $error("unicast flag wrong");
  a_ckign_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    s_end |-> ##3 fifo_wdata_o[`RXSW_A_CKIGN] == $past(frm_i.ck_ign, 3))
    else $error("checksum ignore flag wrong");
  a_raw_l3_checksum_field_word: assert property (@(posedge clk_i) disable iff (rst_i)
    s_end |-> ##4 s_word_b ##0 fifo_wdata_o[31:16] == frm_r.raw_l3_checksum_field)
    else $error("raw checksum field wrong");
  a_wake_word: assert property (@(posedge clk_i) disable iff (rst_i)
    s_end |-> ##2 s_word_c ##0 fifo_wdata_o[`RXSW_C_WAKE] == $past(wake_now, 2)
      && fifo_wdata_o[`RXSW_C_FFAIL] == $past(ffail_now, 2))
    else $error("wake word wrong");
  a_flush_self: assert property (@(posedge clk_i) disable iff (rst_i)
    st_flush |=> ~flush_r)
    else $error("flush bit did not clear itself");
endmodule // rxsw_top

// >>> src/rxsw_defs.svh
// offsets, field positions, reset values and limits of the rx status word builder
// Operation
// - multicast flag bit 24: address top byte lsb set, never for broadcast
// - vlan flag bit 23 when tag removed; tag goes into second word
// - summary error bit 22 when any frame error or checksum error flag set
// - watchdog flag bit 21 when frame over 11264 bytes was truncated
// - runt flag bit 20 for frames under 64 bytes or short frames
// - runt frames reach the host only when keep-bad-frames is set
// - too-long flag bit 19 above programmed maximum, frame not truncated
// - phy receive error flag bit 18 if error seen anywhere in frame
// - alignment bit 17: odd bit count with bad fcs, 10/100 only
// - fcs flag bit 16 on crc mismatch or phy receive error
// - unicast flag bit 15 for unicast destination address
// - checksum-ignore bit 14 when layer-4 checksum could not be computed
// - length in bits 13:0, minus four when fcs stripping is on
// - second word bits 31:16 carry raw layer-3 checksum
// - second word bits 15:0 carry vlan tag: pri, cfi, vid
// - third word bit 15 marks wake frame, deepest suspend with store-wake
// - third word bit 14 wake filter fail, needs pass-wake and store-wake
// - flush returns rx fifo pointers to reset, dropping all contents
// - fifo-disabled status and enabled interrupt rise once fifo stopped
// - flush control bit clears itself when the flush is done
// - disabled interrupt stays until both disabled status bits cleared
`ifndef RXSW_DEFS_SVH
`define RXSW_DEFS_SVH
`define RXSW_CTL_OFF 4'h0
`define RXSW_MAC_OFF 4'h4
`define RXSW_STA_OFF 4'h8
`define RXSW_CNT_OFF 4'hc
`define RXSW_CTL_EN 0
`define RXSW_CTL_KEEP 1
`define RXSW_CTL_STRIP 2
`define RXSW_CTL_FLUSH 3
`define RXSW_CTL_FDIS 4
`define RXSW_CTL_IEN 5
`define RXSW_MAC_RXEN 0
`define RXSW_MAC_RXD 1
`define RXSW_MAC_MAX_LSB 16
`define RXSW_MAX_RST 14'h05ee
`define RXSW_WD_BYTES 14'h2c00
`define RXSW_RUNT_BYTES 14'h0040
`define RXSW_FCS_BYTES 14'h0004
`define RXSW_A_MCAST 24
`define RXSW_A_VLAN 23
`define RXSW_A_ERR 22
`define RXSW_A_WDT 21
`define RXSW_A_RUNT 20
`define RXSW_A_LONG 19
`define RXSW_A_RXE 18
`define RXSW_A_ALN 17
`define RXSW_A_FCS 16
`define RXSW_A_UCAST 15
`define RXSW_A_CKIGN 14
`define RXSW_C_WAKE 15
`define RXSW_C_FFAIL 14
`endif

// >>> src/rxsw_pkg.sv
// types shared by the rx status word builder
package rxsw_pkg;
  typedef enum logic [2:0] {
    RXSW_IDLE, RXSW_RX, RXSW_WC, RXSW_WA, RXSW_WB, RXSW_DROP, RXSW_FLUSH
  } rxsw_state_e;
  typedef enum logic [1:0] {RXSW_SEL_A, RXSW_SEL_B, RXSW_SEL_C} rxsw_sel_e;
  typedef struct packed {
    logic [7:0] da_msb;
    logic bcast;
    logic vlan;
    logic [15:0] vlan_tag_field;
    logic [13:0] bytes;
    logic dribble;
    logic crc_ok;
    logic wd_trunc;
    logic short_frm;
    logic ip_err;
    logic l4_err;
    logic ck_ign;
    logic gig;
    logic [15:0] raw_l3_checksum_field;
    logic wake;
    logic ffail;
  } rxsw_frame_s;
endpackage

// >>> bench/rxsw_fifo_sink.sv
// far-side fifo sink model: takes status words, checks their order, counts events
`timescale 1ns/1ps
module rxsw_fifo_sink (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fifo side of the builder
  input wire logic fifo_we_i,
  input wire rxsw_pkg::rxsw_sel_e fifo_sel_i,
  input wire logic [31:0] fifo_wdata_i,
  input wire logic fifo_commit_i,
  input wire logic fifo_rewind_i,
  input wire logic fifo_ptr_rst_i,
  // captured words and counts
  output logic [31:0] w_a_o,
  output logic [31:0] w_b_o,
  output logic [31:0] w_c_o,
  output logic [7:0] n_commit_o,
  output logic [7:0] n_rewind_o,
  output logic [7:0] n_flush_o,
  output logic seq_err_o
);
  rxsw_pkg::rxsw_sel_e exp_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exp_r <= rxsw_pkg::RXSW_SEL_C;
      seq_err_o <= 1'b0;
      n_commit_o <= 8'h00;
      n_rewind_o <= 8'h00;
      n_flush_o <= 8'h00;
    end else begin
      if (fifo_we_i) begin
        // a frame's words must arrive c, a, b
        if (fifo_sel_i !== exp_r)
          seq_err_o <= 1'b1;
        exp_r <= (fifo_sel_i == rxsw_pkg::RXSW_SEL_C) ? rxsw_pkg::RXSW_SEL_A :
                 (fifo_sel_i == rxsw_pkg::RXSW_SEL_A) ? rxsw_pkg::RXSW_SEL_B :
                 rxsw_pkg::RXSW_SEL_C;
        if (fifo_sel_i == rxsw_pkg::RXSW_SEL_A)
          w_a_o <= fifo_wdata_i;
        if (fifo_sel_i == rxsw_pkg::RXSW_SEL_B)
          w_b_o <= fifo_wdata_i;
        if (fifo_sel_i == rxsw_pkg::RXSW_SEL_C)
          w_c_o <= fifo_wdata_i;
      end
      // commit only travels with the last word, else the frame is torn
      if (fifo_commit_i && !(fifo_we_i && fifo_sel_i == rxsw_pkg::RXSW_SEL_B))
        seq_err_o <= 1'b1;
      if (fifo_commit_i)
        n_commit_o <= n_commit_o + 8'h01;
      if (fifo_rewind_i)
        n_rewind_o <= n_rewind_o + 8'h01;
      // a flush is only counted here; the captured words are kept
      if (fifo_ptr_rst_i)
        n_flush_o <= n_flush_o + 8'h01;
    end
  end
endmodule // rxsw_fifo_sink

// >>> bench/test_rx_frame_status_words.sv
// self-checking bench for the rx status word builder
`timescale 1ns/1ps
module test_rx_frame_status_words;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, w_a, w_b, w_c;
  logic frm_start_i, frm_end_i, phy_err_i, susp3_i, store_wake_i, pass_wake_i;
  rxsw_pkg::rxsw_frame_s frm_i, f;
  logic fifo_we_o, fifo_commit_o, fifo_rewind_o, fifo_ptr_rst_o, mac_receive_register_en_o, rx_disabled_interrupt_o;
  rxsw_pkg::rxsw_sel_e fifo_sel_o;
  logic [31:0] fifo_wdata_o;
  logic [7:0] n_commit, n_rewind, n_flush;
  logic seq_err, strip_b;
  logic [3:0] sel_b;
  logic [13:0] max_b;
  int err_count, samples_checked;
  rxsw_top DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .frm_start_i, .frm_end_i, .phy_err_i, .frm_i,
    .susp3_i, .store_wake_i, .pass_wake_i, .fifo_we_o, .fifo_sel_o, .fifo_wdata_o,
    .fifo_commit_o, .fifo_rewind_o, .fifo_ptr_rst_o, .mac_receive_register_en_o, .rx_disabled_interrupt_o);
  rxsw_fifo_sink u_sink (.clk_i, .rst_i, .fifo_we_i(fifo_we_o), .fifo_sel_i(fifo_sel_o),
    .fifo_wdata_i(fifo_wdata_o), .fifo_commit_i(fifo_commit_o),
    .fifo_rewind_i(fifo_rewind_o), .fifo_ptr_rst_i(fifo_ptr_rst_o), .w_a_o(w_a),
    .w_b_o(w_b), .w_c_o(w_c), .n_commit_o(n_commit), .n_rewind_o(n_rewind),
    .n_flush_o(n_flush), .seq_err_o(seq_err));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one classic cycle; waits on ack, data taken at the ack edge
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel_b;
    wb_dat_i <= d;
    // only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  function automatic logic [31:0] expa(input rxsw_pkg::rxsw_frame_s x, input logic pe);
    logic wdt, rnt, lng, alignment_error_flag, fcs, err;
    wdt = x.wd_trunc | (x.bytes > 14'h2c00);
    rnt = x.short_frm | (x.bytes < 14'h0040);
    lng = x.bytes > max_b;
    alignment_error_flag = x.dribble & ~x.crc_ok & ~x.gig;
    fcs = ~x.crc_ok | pe;
    err = fcs | alignment_error_flag | pe | lng | rnt | wdt | x.ip_err | (x.l4_err & ~x.ck_ign);
    return {7'h00, x.da_msb[0] & ~x.bcast, x.vlan, err, wdt, rnt, lng, pe, alignment_error_flag, fcs,
      ~x.da_msb[0], x.ck_ign, strip_b ? x.bytes - 14'h0004 : x.bytes};
  endfunction
  // m: 0 stored, 1 discarded, 2 start refused
  task automatic frame(input rxsw_pkg::rxsw_frame_s x, input logic pe, input int m);
    logic [7:0] nc, nr;
    logic wk;
    nc = n_commit;
    nr = n_rewind;
    @(posedge clk_i);
    frm_start_i <= 1'b1;
    @(posedge clk_i);
    frm_start_i <= 1'b0;
    phy_err_i <= pe;
    @(posedge clk_i);
    phy_err_i <= 1'b0;
    @(posedge clk_i);
    frm_end_i <= 1'b1;
    frm_i <= x;
    // power levels are settled here, as the builder samples them at frame end
    wk = x.wake & susp3_i & store_wake_i;
    @(posedge clk_i);
    frm_end_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(n_commit, nc + 8'(m == 0));
    chk(n_rewind, nr + 8'(m == 1));
    if (m == 0) begin
      chk(w_a, expa(x, pe));
      chk(w_b, {x.raw_l3_checksum_field, x.vlan ? x.vlan_tag_field : 16'h0000});
      chk(w_c, {16'h0000, wk, wk & x.ffail & pass_wake_i, 14'h0000});
    end
  endtask
  task automatic t_regs;
    wb(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h00000000);
    wb(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h05ee0000);
    wb(1'b1, 4'h2, 32'hffffffff);
    wb(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h00000000);
    wb(1'b1, 4'h4, 32'h05ee0001);
    wb(1'b1, 4'h0, 32'h00000021);
    sel_b = 4'he;
    wb(1'b1, 4'h4, 32'h05ee0000);
    sel_b = 4'hf;
    wb(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h05ee0001);
    chk(mac_receive_register_en_o, 32'h1);
  endtask
  task automatic t_flags;
    f = '0;
    f.da_msb = 8'h01;
    f.vlan = 1'b1;
    f.vlan_tag_field = 16'ha123;
    f.bytes = 14'h0100;
    f.crc_ok = 1'b1;
    f.raw_l3_checksum_field = 16'h5a3c;
    frame(f, 1'b1, 0);
    f.da_msb = 8'hff;
    f.bcast = 1'b1;
    f.vlan = 1'b0;
    frame(f, 1'b0, 0);
    f.da_msb = 8'h02;
    f.bcast = 1'b0;
    f.l4_err = 1'b1;
    f.ck_ign = 1'b1;
    frame(f, 1'b0, 0);
    f.ck_ign = 1'b0;
    f.ip_err = 1'b1;
    frame(f, 1'b0, 0);
  endtask
  task automatic t_runt_long;
    f = '0;
    f.crc_ok = 1'b1;
    f.bytes = 14'h003f;
    frame(f, 1'b0, 1);
    wb(1'b1, 4'h0, 32'h00000027);
    strip_b = 1'b1;
    wb(1'b1, 4'h4, 32'h01000001);
    max_b = 14'h0100;
    frame(f, 1'b0, 0);
    f.bytes = 14'h0040;
    f.short_frm = 1'b1;
    frame(f, 1'b0, 0);
    f.short_frm = 1'b0;
    f.bytes = 14'h0100;
    frame(f, 1'b0, 0);
    f.bytes = 14'h0101;
    f.wd_trunc = 1'b1;
    frame(f, 1'b0, 0);
    f.wd_trunc = 1'b0;
    f.bytes = 14'h2c01;
    frame(f, 1'b0, 0);
  endtask
  task automatic t_aln_wake;
    f = '0;
    f.bytes = 14'h0080;
    f.dribble = 1'b1;
    frame(f, 1'b0, 0);
    f.gig = 1'b1;
    susp3_i <= 1'b1;
    store_wake_i <= 1'b1;
    pass_wake_i <= 1'b1;
    f.wake = 1'b1;
    f.ffail = 1'b1;
    frame(f, 1'b0, 0);
    pass_wake_i <= 1'b0;
    frame(f, 1'b0, 0);
    wb(1'b0, 4'h8, 32'h0);
    chk(rd, expa(f, 1'b0));
    wb(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h0001000c);
  endtask
  task automatic t_flush;
    // stop the receiver and see it stopped before touching the fifo
    wb(1'b1, 4'h4, 32'h01000000);
    repeat (5) @(posedge clk_i);
    wb(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h01000002);
    chk(rx_disabled_interrupt_o, 32'h1);
    frame(f, 1'b0, 2);
    wb(1'b1, 4'h0, 32'h00000020);
    repeat (5) @(posedge clk_i);
    wb(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h00000030);
    wb(1'b1, 4'h0, 32'h00000030);
    repeat (3) @(posedge clk_i);
    chk(rx_disabled_interrupt_o, 32'h1);
    wb(1'b1, 4'h4, 32'h01000002);
    repeat (3) @(posedge clk_i);
    chk(rx_disabled_interrupt_o, 32'h0);
    wb(1'b1, 4'h0, 32'h00000028);
    repeat (6) @(posedge clk_i);
    chk(n_flush, 32'h1);
    wb(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h00000020);
  endtask
  task automatic finish_test;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // a hang is cut well past the few hundred cycles the run needs
  initial begin
    #(50 * 5000);
    err_count++;
    finish_test;
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, frm_start_i, frm_end_i, phy_err_i} = 7'h7f & 7'h40;
    {susp3_i, store_wake_i, pass_wake_i, strip_b} = 4'h0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hf;
    sel_b = 4'hf;
    wb_dat_i = 32'h0;
    frm_i = '0;
    max_b = 14'h05ee;
    err_count = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_flags;
    t_runt_long;
    t_aln_wake;
    t_flush;
    chk(seq_err, 32'h0);
    finish_test;
  end
endmodule // test_rx_frame_status_words
